// ### logic/dacog_pkg.sv
// Package for the converter offset, gain and auxiliary configuration bank.
// Assumes a byte-wide register port with a 7-bit register address.
package dacog_pkg;

  // -------------------------------------------------------------------
  // Register port geometry
  // -------------------------------------------------------------------
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 8;
  localparam int SAMPLE_W = 16;
  localparam int CODE_W   = 10;

  // -------------------------------------------------------------------
  // Register addresses
  // -------------------------------------------------------------------
  localparam logic [6:0] ADDR_IOFF_LO  = 7'h3C;
  localparam logic [6:0] ADDR_IOFF_HI  = 7'h3D;
  localparam logic [6:0] ADDR_QOFF_LO  = 7'h3E;
  localparam logic [6:0] ADDR_QOFF_HI  = 7'h3F;
  localparam logic [6:0] ADDR_IFS_LO   = 7'h40;
  localparam logic [6:0] ADDR_ICTRL    = 7'h41;
  localparam logic [6:0] ADDR_IAUX_LO  = 7'h42;
  localparam logic [6:0] ADDR_IAUX_CTL = 7'h43;
  localparam logic [6:0] ADDR_QFS_LO   = 7'h44;
  localparam logic [6:0] ADDR_QCTRL    = 7'h45;

  // -------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------
  localparam int BIT_MAIN_SLEEP = 7;
  localparam int BIT_AUX_SIGN   = 7;
  localparam int BIT_AUX_DIR    = 6;
  localparam int BIT_AUX_SLEEP  = 5;
  localparam int HI_CODE_W      = 2;

  // -------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------
  localparam logic [7:0] RST_OFFSET_BYTE = 8'h00;
  localparam logic [7:0] RST_FS_LO       = 8'hF9;
  localparam logic [1:0] RST_FS_HI       = 2'h1;
  localparam logic [7:0] RST_AUX_LO      = 8'h00;
  localparam logic [1:0] RST_AUX_HI      = 2'h0;
  localparam logic       RST_BIT         = 1'b0;
  localparam logic [7:0] RD_ZERO         = 8'h00;

endpackage

// ### logic/dacog_offset_add.sv
// Per-channel offset adder for the in-phase and quadrature sample paths.
// Assumes samples and offsets arrive on the same clock; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module dacog_offset_add
  import dacog_pkg::*;
(
  input  wire logic [SAMPLE_W-1:0] samp_i,
  input  wire logic [SAMPLE_W-1:0] samp_q,
  input  wire logic [SAMPLE_W-1:0] off_i,
  input  wire logic [SAMPLE_W-1:0] off_q,
  output logic      [SAMPLE_W-1:0] sum_i,
  output logic      [SAMPLE_W-1:0] sum_q
);

  logic [SAMPLE_W-1:0] samp_a [2];
  logic [SAMPLE_W-1:0] off_a  [2];
  logic [SAMPLE_W-1:0] sum_a  [2];

  // Channel 0 is in-phase, channel 1 quadrature
  assign samp_a[0] = samp_i;
  assign samp_a[1] = samp_q;
  assign off_a[0]  = off_i;
  assign off_a[1]  = off_q;
  assign sum_i     = sum_a[0];
  assign sum_q     = sum_a[1];

  // Modular add, carry out dropped on purpose
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign sum_a[ch] = SAMPLE_W'(samp_a[ch] + off_a[ch]);
  end

endmodule
`default_nettype wire

// ### logic/dacog_pair_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock; head entry and both handshake flags are flops.
`timescale 1ns/1ps
`default_nettype none
module dacog_pair_buf #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         s_valid,
  output logic              s_ready,
  input  wire logic [W-1:0] s_data,
  output logic              m_valid,
  input  wire logic         m_ready,
  output logic      [W-1:0] m_data
);

  logic [W-1:0] head_r;
  logic [W-1:0] tail_r;
  logic [1:0]   cnt_r;
  logic [1:0]   cnt_nxt;
  logic         push;
  logic         pop;

  // Handshakes on both sides
  assign push    = s_valid && s_ready;
  assign pop     = m_valid && m_ready;
  assign m_data  = head_r;

  // Occupancy next value
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = 2'(cnt_r + 2'h1);
    end else if (pop && !push) begin
      cnt_nxt = 2'(cnt_r - 2'h1);
    end
  end

  // Occupancy and registered flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r   <= 2'h0;
      m_valid <= 1'b0;
      s_ready <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      m_valid <= (cnt_nxt != 2'h0);
      s_ready <= (cnt_nxt != 2'h2);
    end
  end

  // Entry storage, head shifts forward on pop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      head_r <= '0;
      tail_r <= '0;
    end else begin
      if ((cnt_r == 2'h0 && push) || (cnt_r == 2'h1 && push && pop)) begin
        head_r <= s_data;
      end else if (cnt_r == 2'h2 && pop) begin
        head_r <= tail_r;
      end
      if (cnt_r == 2'h1 && push && !pop) begin
        tail_r <= s_data;
      end
    end
  end

endmodule
`default_nettype wire

// ### logic/dacog_config_bank.sv
// Configuration bank for a dual-channel converter: offsets, full-scale
// codes, sleep controls and in-phase auxiliary current settings.
// Assumes a byte register port on clk and a sample stream on the same clock.
//
// Contract
// - Each in-phase sample gets the 16-bit offset from 0x3C (low) and 0x3D (high) added, reset zero.
// - Each quadrature sample gets the 16-bit offset from 0x3E (low) and 0x3F (high) added, reset zero.
// - The in-phase full-scale code is 0x40 low byte plus 0x41 bits 1:0, resetting to 0x1F9.
// - The quadrature full-scale code is 0x44 low byte plus 0x45 bits 1:0, resetting to 0x1F9.
// - Bit 7 of 0x41 puts the in-phase main converter into fast-wake sleep.
// - Bit 7 of 0x45 puts the quadrature main converter into fast-wake sleep, reset zero.
// - The in-phase auxiliary magnitude is 0x42 low byte plus 0x43 bits 1:0.
// - Bit 7 of 0x43 picks the auxiliary sign: 0 true output, 1 complement output.
// - Bit 6 of 0x43 picks auxiliary direction: 0 source, 1 sink, reset zero.
// - Bit 5 of 0x43 puts the in-phase auxiliary converter to sleep, reset zero.
`timescale 1ns/1ps
`default_nettype none
module dacog_config_bank
  import dacog_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  // Register port
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  output logic      [DATA_W-1:0]   reg_rdata,
  output logic                     reg_rvalid,
  // Sample stream in
  input  wire logic                smp_valid,
  output logic                     smp_ready,
  input  wire logic [SAMPLE_W-1:0] smp_i,
  input  wire logic [SAMPLE_W-1:0] smp_q,
  // Sample stream out, offsets applied
  output logic                     out_valid,
  input  wire logic                out_ready,
  output logic      [SAMPLE_W-1:0] out_i,
  output logic      [SAMPLE_W-1:0] out_q,
  // Analog controls
  output logic      [CODE_W-1:0]   inphase_fullscale_code,
  output logic      [CODE_W-1:0]   quad_fullscale_code,
  output logic                     inphase_main_sleep,
  output logic                     quad_main_sleep,
  output logic      [CODE_W-1:0]   inphase_aux_magnitude,
  output logic                     inphase_aux_to_complement,
  output logic                     inphase_aux_sink,
  output logic                     inphase_aux_sleep
);

  // -------------------------------------------------------------------
  // Register storage
  // -------------------------------------------------------------------
  logic [7:0]  ioff_lo_r;
  logic [7:0]  ioff_hi_r;
  logic [7:0]  qoff_lo_r;
  logic [7:0]  qoff_hi_r;
  logic [7:0]  ifs_lo_r;
  logic [1:0]  ifs_hi_r;
  logic        isleep_r;
  logic [7:0]  qfs_lo_r;
  logic [1:0]  qfs_hi_r;
  logic        qsleep_r;
  logic [7:0]  iaux_lo_r;
  logic [1:0]  iaux_hi_r;
  logic        iaux_sign_r;
  logic        iaux_dir_r;
  logic        iaux_sleep_r;
  logic [7:0]  rdata_nxt;

  logic [SAMPLE_W-1:0] off_i;
  logic [SAMPLE_W-1:0] off_q;
  logic [SAMPLE_W-1:0] sum_i;
  logic [SAMPLE_W-1:0] sum_q;
  logic [2*SAMPLE_W-1:0] buf_out;

  // Write strobe per address
  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = reg_wr && (reg_addr == a);
  endfunction

  // -------------------------------------------------------------------
  // Offset registers
  // -------------------------------------------------------------------
  // In-phase offset bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ioff_lo_r <= RST_OFFSET_BYTE;
      ioff_hi_r <= RST_OFFSET_BYTE;
    end else begin
      if (hit(ADDR_IOFF_LO)) ioff_lo_r <= reg_wdata;
      if (hit(ADDR_IOFF_HI)) ioff_hi_r <= reg_wdata;
    end
  end

  // Quadrature offset bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qoff_lo_r <= RST_OFFSET_BYTE;
      qoff_hi_r <= RST_OFFSET_BYTE;
    end else begin
      if (hit(ADDR_QOFF_LO)) qoff_lo_r <= reg_wdata;
      if (hit(ADDR_QOFF_HI)) qoff_hi_r <= reg_wdata;
    end
  end

  // -------------------------------------------------------------------
  // Main converter controls
  // -------------------------------------------------------------------
  // In-phase full-scale code and sleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ifs_lo_r <= RST_FS_LO;
      ifs_hi_r <= RST_FS_HI;
      isleep_r <= RST_BIT;
    end else begin
      if (hit(ADDR_IFS_LO)) ifs_lo_r <= reg_wdata;
      if (hit(ADDR_ICTRL)) begin
        ifs_hi_r <= reg_wdata[HI_CODE_W-1:0];
        isleep_r <= reg_wdata[BIT_MAIN_SLEEP];
      end
    end
  end

  // Quadrature full-scale code and sleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qfs_lo_r <= RST_FS_LO;
      qfs_hi_r <= RST_FS_HI;
      qsleep_r <= RST_BIT;
    end else begin
      if (hit(ADDR_QFS_LO)) qfs_lo_r <= reg_wdata;
      if (hit(ADDR_QCTRL)) begin
        qfs_hi_r <= reg_wdata[HI_CODE_W-1:0];
        qsleep_r <= reg_wdata[BIT_MAIN_SLEEP];
      end
    end
  end

  // -------------------------------------------------------------------
  // Auxiliary converter controls
  // -------------------------------------------------------------------
  // In-phase auxiliary magnitude, sign, direction and sleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      iaux_lo_r    <= RST_AUX_LO;
      iaux_hi_r    <= RST_AUX_HI;
      iaux_sign_r  <= RST_BIT;
      iaux_dir_r   <= RST_BIT;
      iaux_sleep_r <= RST_BIT;
    end else begin
      if (hit(ADDR_IAUX_LO)) iaux_lo_r <= reg_wdata;
      if (hit(ADDR_IAUX_CTL)) begin
        iaux_hi_r    <= reg_wdata[HI_CODE_W-1:0];
        iaux_sign_r  <= reg_wdata[BIT_AUX_SIGN];
        iaux_dir_r   <= reg_wdata[BIT_AUX_DIR];
        iaux_sleep_r <= reg_wdata[BIT_AUX_SLEEP];
      end
    end
  end

  // -------------------------------------------------------------------
  // Analog control outputs
  // -------------------------------------------------------------------
  // Registered copies so every output leaves from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inphase_fullscale_code    <= {RST_FS_HI, RST_FS_LO};
      quad_fullscale_code       <= {RST_FS_HI, RST_FS_LO};
      inphase_main_sleep        <= RST_BIT;
      quad_main_sleep           <= RST_BIT;
      inphase_aux_magnitude     <= {RST_AUX_HI, RST_AUX_LO};
      inphase_aux_to_complement <= RST_BIT;
      inphase_aux_sink          <= RST_BIT;
      inphase_aux_sleep         <= RST_BIT;
    end else begin
      inphase_fullscale_code    <= {ifs_hi_r, ifs_lo_r};
      quad_fullscale_code       <= {qfs_hi_r, qfs_lo_r};
      inphase_main_sleep        <= isleep_r;
      quad_main_sleep           <= qsleep_r;
      inphase_aux_magnitude     <= {iaux_hi_r, iaux_lo_r};
      inphase_aux_to_complement <= iaux_sign_r;
      inphase_aux_sink          <= iaux_dir_r;
      inphase_aux_sleep         <= iaux_sleep_r;
    end
  end

  // -------------------------------------------------------------------
  // Readback
  // -------------------------------------------------------------------
  // Read mux, undefined bits and unmapped addresses give zero
  always_comb begin
    rdata_nxt = RD_ZERO;
    unique case (reg_addr)
      ADDR_IOFF_LO:  rdata_nxt = ioff_lo_r;
      ADDR_IOFF_HI:  rdata_nxt = ioff_hi_r;
      ADDR_QOFF_LO:  rdata_nxt = qoff_lo_r;
      ADDR_QOFF_HI:  rdata_nxt = qoff_hi_r;
      ADDR_IFS_LO:   rdata_nxt = ifs_lo_r;
      ADDR_ICTRL:    rdata_nxt = {isleep_r, 5'h00, ifs_hi_r};
      ADDR_IAUX_LO:  rdata_nxt = iaux_lo_r;
      ADDR_IAUX_CTL: rdata_nxt = {iaux_sign_r, iaux_dir_r, iaux_sleep_r, 3'h0, iaux_hi_r};
      ADDR_QFS_LO:   rdata_nxt = qfs_lo_r;
      ADDR_QCTRL:    rdata_nxt = {qsleep_r, 5'h00, qfs_hi_r};
      default:       rdata_nxt = RD_ZERO;
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= RD_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rdata_nxt;
    end
  end

  // -------------------------------------------------------------------
  // Sample datapath
  // -------------------------------------------------------------------
  // Offsets applied to samples as they enter the buffer
  assign off_i = {ioff_hi_r, ioff_lo_r};
  assign off_q = {qoff_hi_r, qoff_lo_r};

  dacog_offset_add u_add (
    .samp_i (smp_i),
    .samp_q (smp_q),
    .off_i  (off_i),
    .off_q  (off_q),
    .sum_i  (sum_i),
    .sum_q  (sum_q)
  );

  // Buffer keeps words while the receiver stalls
  dacog_pair_buf #(
    .W (2*SAMPLE_W)
  ) u_buf (
    .clk     (clk),
    .rst     (rst),
    .s_valid (smp_valid),
    .s_ready (smp_ready),
    .s_data  ({sum_i, sum_q}),
    .m_valid (out_valid),
    .m_ready (out_ready),
    .m_data  (buf_out)
  );

  assign out_i = buf_out[2*SAMPLE_W-1:SAMPLE_W];
  assign out_q = buf_out[SAMPLE_W-1:0];

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  sequence s_accept_empty;
    smp_valid && smp_ready && !out_valid;
  endsequence

  sequence s_write_ctl(logic [ADDR_W-1:0] a);
    reg_wr && !reg_rd && reg_addr == a;
  endsequence

  // Cycle with no write to the given register
  sequence s_no_write(logic [ADDR_W-1:0] a);
    !(reg_wr && reg_addr == a);
  endsequence

  a_ioffset_sum: assert property (@(posedge clk) disable iff (rst)
    s_accept_empty |=> out_valid && out_i == SAMPLE_W'($past(smp_i) + $past(off_i)))
    else $error("in-phase sample missing offset");

  a_qoffset_sum: assert property (@(posedge clk) disable iff (rst)
    s_accept_empty |=> out_valid && out_q == SAMPLE_W'($past(smp_q) + $past(off_q)))
    else $error("quadrature sample missing offset");

  a_ifs_code_out: assert property (@(posedge clk) disable iff (rst)
    (s_write_ctl(ADDR_IFS_LO) ##1 s_no_write(ADDR_ICTRL)) |=>
      inphase_fullscale_code[7:0] == $past(reg_wdata, 2))
    else $error("in-phase full-scale code not updated");

  a_ifs_high_out: assert property (@(posedge clk) disable iff (rst)
    s_write_ctl(ADDR_ICTRL) |-> ##2 inphase_fullscale_code[9:8] == $past(reg_wdata[1:0], 2))
    else $error("in-phase full-scale high bits not updated");

  a_qfs_code_out: assert property (@(posedge clk) disable iff (rst)
    s_write_ctl(ADDR_QCTRL) ##1 1'b1 |=>
      quad_fullscale_code[9:8] == $past(reg_wdata[1:0], 2))
    else $error("quadrature full-scale high bits not updated");

  a_qfs_low_out: assert property (@(posedge clk) disable iff (rst)
    s_write_ctl(ADDR_QFS_LO) |-> ##2 quad_fullscale_code[7:0] == $past(reg_wdata, 2))
    else $error("quadrature full-scale low bits not updated");

  a_isleep_follow: assert property (@(posedge clk) disable iff (rst)
    s_write_ctl(ADDR_ICTRL) |-> ##2 inphase_main_sleep == $past(reg_wdata[BIT_MAIN_SLEEP], 2))
    else $error("in-phase sleep did not follow write");

  a_qsleep_follow: assert property (@(posedge clk) disable iff (rst)
    s_write_ctl(ADDR_QCTRL) |-> ##2 quad_main_sleep == $past(reg_wdata[BIT_MAIN_SLEEP], 2))
    else $error("quadrature sleep did not follow write");

  a_aux_mag_out: assert property (@(posedge clk) disable iff (rst)
    s_write_ctl(ADDR_IAUX_LO) ##1 s_no_write(ADDR_IAUX_LO) |=>
      inphase_aux_magnitude[7:0] == $past(reg_wdata, 2))
    else $error("aux magnitude not updated");

  a_aux_high_out: assert property (@(posedge clk) disable iff (rst)
    s_write_ctl(ADDR_IAUX_CTL) |-> ##2 inphase_aux_magnitude[9:8] == $past(reg_wdata[1:0], 2))
    else $error("aux magnitude high bits not updated");

  a_aux_ctl_bits: assert property (@(posedge clk) disable iff (rst)
    s_write_ctl(ADDR_IAUX_CTL) |-> ##2
      {inphase_aux_to_complement, inphase_aux_sink, inphase_aux_sleep} == $past(reg_wdata[7:5], 2))
    else $error("aux sign, direction or sleep wrong");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == ADDR_ICTRL || reg_addr == ADDR_QCTRL) |=> reg_rvalid && reg_rdata[6:2] == 5'h00)
    else $error("reserved bits read nonzero");

  a_readback_ioff: assert property (@(posedge clk) disable iff (rst)
    s_write_ctl(ADDR_IOFF_HI) ##1 (reg_rd && !reg_wr && reg_addr == ADDR_IOFF_HI) |=>
      reg_rdata == $past(reg_wdata, 2))
    else $error("offset readback mismatch");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rd && (reg_addr < ADDR_IOFF_LO || reg_addr > ADDR_QCTRL) |=> reg_rdata == RD_ZERO)
    else $error("unmapped address read nonzero");

  a_read_answer: assert property (@(posedge clk) disable iff (rst)
    reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");

  a_rvalid_pulse: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> !reg_rvalid)
    else $error("read answer without strobe");

  a_stall_holds: assert property (@(posedge clk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_i) && $stable(out_q))
    else $error("stalled word changed");

endmodule
`default_nettype wire

// ### tb/dacog_config_bank_tb.sv
// Self-checking bench for the converter configuration bank.
// Assumes the design package and modules are compiled first; the bench
// drives every port itself and keeps a register and stream model.
`timescale 1ns/1ps
`default_nettype none
module dacog_config_bank_tb import dacog_pkg::*;;

  // -------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------
  logic                clk;
  logic                rst;
  logic                reg_wr;
  logic                reg_rd;
  logic [ADDR_W-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wdata;
  logic [DATA_W-1:0]   reg_rdata;
  logic                reg_rvalid;
  logic                smp_valid;
  logic                smp_ready;
  logic [SAMPLE_W-1:0] smp_i;
  logic [SAMPLE_W-1:0] smp_q;
  logic                out_valid;
  logic                out_ready;
  logic [SAMPLE_W-1:0] out_i;
  logic [SAMPLE_W-1:0] out_q;
  logic [CODE_W-1:0]   fs_i;
  logic [CODE_W-1:0]   fs_q;
  logic                slp_i;
  logic                slp_q;
  logic [CODE_W-1:0]   aux_mag;
  logic                aux_neg;
  logic                aux_sink;
  logic                aux_slp;
  int                  error_cnt;
  int                  n_tests;
  int                  cyc_cnt;
  int                  mdl [128];
  int                  msk [128];
  logic [15:0]         lf = 16'h0050;
  logic [15:0]         qi [$];
  logic [15:0]         qq [$];
  logic [6:0]          adr [10] = '{ADDR_IOFF_LO, ADDR_IOFF_HI, ADDR_QOFF_LO, ADDR_QOFF_HI, ADDR_IFS_LO,
                                    ADDR_ICTRL, ADDR_IAUX_LO, ADDR_IAUX_CTL, ADDR_QFS_LO, ADDR_QCTRL};

  dacog_config_bank uut (
    .clk                       (clk),
    .rst                       (rst),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_rdata                 (reg_rdata),
    .reg_rvalid                (reg_rvalid),
    .smp_valid                 (smp_valid),
    .smp_ready                 (smp_ready),
    .smp_i                     (smp_i),
    .smp_q                     (smp_q),
    .out_valid                 (out_valid),
    .out_ready                 (out_ready),
    .out_i                     (out_i),
    .out_q                     (out_q),
    .inphase_fullscale_code    (fs_i),
    .quad_fullscale_code       (fs_q),
    .inphase_main_sleep        (slp_i),
    .quad_main_sleep           (slp_q),
    .inphase_aux_magnitude     (aux_mag),
    .inphase_aux_to_complement (aux_neg),
    .inphase_aux_sink          (aux_sink),
    .inphase_aux_sleep         (aux_slp)
  );

  // -------------------------------------------------------------------
  // Clock, timeout and helpers
  // -------------------------------------------------------------------
  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Register write, mirrored into the model with undefined bits dropped
  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    mdl[a] = int'(d) & msk[a];
  endtask

  // Register read, answer expected one cycle after the strobe is taken
  task automatic reg_check(input logic [6:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check({15'h0, reg_rvalid}, 16'h1);
    check({8'h0, reg_rdata}, 16'(mdl[a]));
  endtask

  // Write, then read the same register on the very next cycle
  task automatic reg_wr_rd(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    mdl[a] = int'(d) & msk[a];
    @(posedge clk);
    reg_rd    <= 1'b0;
    #1;
    check({8'h0, reg_rdata}, 16'(mdl[a]));
  endtask

  // Model back to the reset value of every register
  task automatic model_reset();
    foreach (mdl[k]) mdl[k] = 0;
    mdl[8'h40] = 8'hF9;
    mdl[8'h44] = 8'hF9;
    mdl[8'h41] = 8'h01;
    mdl[8'h45] = 8'h01;
  endtask

  // All mapped registers, an unmapped one and every analog control
  task automatic check_all();
    foreach (adr[k]) reg_check(adr[k]);
    reg_check(7'h46);
    repeat (2) @(posedge clk);
    #1;
    check({6'h0, fs_i}, 16'(((mdl[8'h41] & 3) << 8) | mdl[8'h40]));
    check({6'h0, fs_q}, 16'(((mdl[8'h45] & 3) << 8) | mdl[8'h44]));
    check({15'h0, slp_i}, 16'((mdl[8'h41] >> 7) & 1));
    check({15'h0, slp_q}, 16'((mdl[8'h45] >> 7) & 1));
    check({6'h0, aux_mag}, 16'(((mdl[8'h43] & 3) << 8) | mdl[8'h42]));
    check({15'h0, aux_neg}, 16'((mdl[8'h43] >> 7) & 1));
    check({15'h0, aux_sink}, 16'((mdl[8'h43] >> 6) & 1));
    check({15'h0, aux_slp}, 16'((mdl[8'h43] >> 5) & 1));
  endtask

  // Sample stream with a full stall first, then random stalls both sides
  task automatic stream(input int n, input int hold);
    int          sent;
    int          got;
    int          cyc;
    logic [15:0] oi;
    logic [15:0] oq;
    sent = 0;
    got  = 0;
    cyc  = 0;
    oi   = 16'((mdl[8'h3D] << 8) | mdl[8'h3C]);
    oq   = 16'((mdl[8'h3F] << 8) | mdl[8'h3E]);
    while (got < n && cyc < 3000) begin
      @(posedge clk);
      if (smp_valid && smp_ready) begin
        qi.push_back(smp_i + oi);
        qq.push_back(smp_q + oq);
        sent++;
      end
      if (out_valid && out_ready && qi.size() > 0) begin
        check(out_i, qi.pop_front());
        check(out_q, qq.pop_front());
        got++;
      end
      if (cyc == hold) begin
        check(16'(sent), 16'h2);
        check({15'h0, smp_ready}, 16'h0);
      end
      if (!smp_valid || smp_ready) begin
        smp_valid <= (sent < n) && (cyc < hold || rnd() > 16'h5000);
        smp_i     <= rnd();
        smp_q     <= rnd();
      end
      out_ready <= (cyc >= hold) && (rnd() > 16'h4000);
      cyc++;
    end
    smp_valid <= 1'b0;
    check(16'(got), 16'(n));
  endtask

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    clk       = 1'b0;
    rst       = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
    smp_valid = 1'b0;
    smp_i     = 16'h0000;
    smp_q     = 16'h0000;
    out_ready = 1'b0;
    error_cnt = 0;
    n_tests   = 0;
    cyc_cnt   = 0;
    foreach (msk[k]) msk[k] = 0;
    foreach (adr[k]) msk[adr[k]] = 8'hFF;
    msk[8'h41] = 8'h83;
    msk[8'h45] = 8'h83;
    msk[8'h43] = 8'hE3;
    model_reset();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    check_all();
    $display("test reset values done");
    for (int r = 0; r < 4; r++) begin
      foreach (adr[k]) reg_write(adr[k], (r == 0) ? 8'hFF : 8'(rnd()));
      reg_wr_rd(ADDR_IOFF_HI, 8'(rnd()));
      reg_write(7'h3B, 8'hFF);
      reg_write(7'h46, 8'hFF);
      check_all();
    end
    $display("test register access done");
    for (int r = 0; r < 3; r++) begin
      foreach (adr[k]) if (k < 4) reg_write(adr[k], (r == 2) ? 8'hFF : 8'(rnd()));
      stream(40, 8);
    end
    $display("test sample offsets done");
    // Reset in mid-run, every register must go back to its reset value
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    model_reset();
    check_all();
    $display("test mid-run reset done");
    finish_test();
  end

endmodule
`default_nettype wire
